//--- ddc_pkg.sv
// Purpose: Shared constants and types for the dual channel DAC output control block.
// Assumes: 8-bit register bus, one 200 MHz clock, synchronous active-low reset.
// Notes:   Every offset, field position and reset value is named here once.
package ddc_pkg;

    localparam int NUM_CH    = 2;
    localparam int CODE_W    = 8;
    localparam int TAP_COUNT = 256;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 8;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFF_MODE     = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CODE0    = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CODE1    = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_MODE_BIT = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h10;

    // Mode register fields: channel n enable sits at bit n.
    localparam int MODE_EN_LSB = 0;
    localparam int MODE_EN_W   = NUM_CH;
    localparam logic [MODE_EN_W-1:0] MODE_RESET = 2'h3;
    localparam logic [CODE_W-1:0]    CODE_RESET = 8'h00;

    // Single-bit access register fields.
    localparam int BITOP_IDX_LSB = 0;
    localparam int BITOP_IDX_W   = 3;
    localparam int BITOP_VAL_POS = 7;

    // Status register fields.
    localparam int STAT_OUT_EN_LSB = 0;
    localparam int STAT_STANDBY    = 2;

    typedef enum logic [1:0] {
        DDC_PWR_ACTIVE  = 2'h1,
        DDC_PWR_STANDBY = 2'h2
    } ddc_pwr_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } ddc_bus_req_s;

endpackage : ddc_pkg

//--- ddc_tap_decoder.sv
// Purpose: One channel tap selector: registered one-hot tap select and output enable.
// Assumes: Code and enable come from logic on the same clock.
// Notes:   All taps are released together whenever the channel is disabled.
`timescale 1ns/100ps
module ddc_tap_decoder (
    input  wire logic                             i_clk,
    input  wire logic                             i_rst_n,
    input  wire logic                             i_en,
    input  wire logic [ddc_pkg::CODE_W-1:0]       i_code,
    output logic      [ddc_pkg::TAP_COUNT-1:0]    o_tap_sel,
    output logic                                  o_out_en
);

    logic [ddc_pkg::TAP_COUNT-1:0] tap_reg;
    logic [ddc_pkg::TAP_COUNT-1:0] tap_next;
    logic                          en_reg;
    logic                          en_next;

    // A one-hot select means no two taps can short the string together.
    always_comb begin
        en_next = i_en;
        for (int t = 0; t < ddc_pkg::TAP_COUNT; t++) begin
            tap_next[t] = i_en && (i_code == t[ddc_pkg::CODE_W-1:0]);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tap_reg <= '0;
            en_reg  <= 1'b0;
        end else begin
            tap_reg <= tap_next;
            en_reg  <= en_next;
        end
    end

    assign o_tap_sel = tap_reg;
    assign o_out_en  = en_reg;

endmodule : ddc_tap_decoder

//--- ddc_dac_ctrl.sv
// Purpose: Register file and tap control for a two channel 8-bit resistor string DAC.
// Assumes: Plain register port; read data are valid in the cycle after the read strobe.
// Notes:   Tap select n connects string tap n, worth lower ref plus n/256 of the span.
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
module ddc_dac_ctrl (
    input  wire logic                               I_REF_CLK,
    input  wire logic                               I_RST_N,
    input  wire logic [ddc_pkg::ADDR_W-1:0]         I_ADDR,
    input  wire logic [ddc_pkg::DATA_W-1:0]         I_WDATA,
    input  wire logic                               I_WR,
    input  wire logic                               I_RD,
    output logic      [ddc_pkg::DATA_W-1:0]         O_RDATA,
    output logic      [ddc_pkg::TAP_COUNT-1:0]      O_TAP_SEL0,
    output logic      [ddc_pkg::TAP_COUNT-1:0]      O_TAP_SEL1,
    output logic      [ddc_pkg::NUM_CH-1:0]         O_OUT_EN,
    output logic                                    O_STANDBY
);

    ddc_pkg::ddc_bus_req_s bus;

    logic [ddc_pkg::MODE_EN_W-1:0] mode_reg;
    logic [ddc_pkg::MODE_EN_W-1:0] mode_next;
    logic [ddc_pkg::CODE_W-1:0]    code_reg  [ddc_pkg::NUM_CH];
    logic [ddc_pkg::CODE_W-1:0]    code_next [ddc_pkg::NUM_CH];
    logic [ddc_pkg::DATA_W-1:0]    rdata_reg;
    logic [ddc_pkg::DATA_W-1:0]    rdata_next;
    ddc_pkg::ddc_pwr_e             pwr_reg;
    ddc_pkg::ddc_pwr_e             pwr_next;

    logic [ddc_pkg::TAP_COUNT-1:0] tap_sel [ddc_pkg::NUM_CH];
    logic [ddc_pkg::NUM_CH-1:0]    out_en;

    function automatic logic ddc_hit(input logic [ddc_pkg::ADDR_W-1:0] addr,
                                     input logic [ddc_pkg::ADDR_W-1:0] off);
        ddc_hit = (addr == off);
    endfunction : ddc_hit

    function automatic logic [ddc_pkg::ADDR_W-1:0] ddc_code_off(input int ch);
        ddc_code_off = (ch == 0) ? ddc_pkg::OFF_CODE0 : ddc_pkg::OFF_CODE1;
    endfunction : ddc_code_off

    assign bus.addr  = I_ADDR;
    assign bus.wdata = I_WDATA;
    assign bus.wr    = I_WR;
    assign bus.rd    = I_RD;

    // Mode register: whole-byte writes and single-bit set or clear.
    always_comb begin
        logic [ddc_pkg::BITOP_IDX_W-1:0] idx;
        idx       = bus.wdata[ddc_pkg::BITOP_IDX_LSB +: ddc_pkg::BITOP_IDX_W];
        mode_next = mode_reg;
        if (bus.wr && ddc_hit(bus.addr, ddc_pkg::OFF_MODE)) begin
            mode_next = bus.wdata[ddc_pkg::MODE_EN_LSB +: ddc_pkg::MODE_EN_W];
        end else if (bus.wr && ddc_hit(bus.addr, ddc_pkg::OFF_MODE_BIT)) begin
            // Bit operations on reserved positions have nothing to change.
            for (int b = 0; b < ddc_pkg::MODE_EN_W; b++) begin
                if (idx == b[ddc_pkg::BITOP_IDX_W-1:0]) begin
                    mode_next[b] = bus.wdata[ddc_pkg::BITOP_VAL_POS];
                end
            end
        end
    end

    // Code registers hold their value until the next write to them.
    always_comb begin
        for (int c = 0; c < ddc_pkg::NUM_CH; c++) begin
            code_next[c] = code_reg[c];
            if (bus.wr && ddc_hit(bus.addr, ddc_code_off(c))) begin
                code_next[c] = bus.wdata;
            end
        end
    end

    // Read data, zero for unmapped addresses and reserved bits.
    always_comb begin
        rdata_next = '0;
        if (bus.rd) begin
            if (ddc_hit(bus.addr, ddc_pkg::OFF_MODE)) begin
                rdata_next[ddc_pkg::MODE_EN_LSB +: ddc_pkg::MODE_EN_W] = mode_reg;
            end else if (ddc_hit(bus.addr, ddc_code_off(0))) begin
                rdata_next = code_reg[0];
            end else if (ddc_hit(bus.addr, ddc_code_off(1))) begin
                rdata_next = code_reg[1];
            end else if (ddc_hit(bus.addr, ddc_pkg::OFF_STATUS)) begin
                rdata_next[ddc_pkg::STAT_OUT_EN_LSB +: ddc_pkg::NUM_CH] = out_en;
                rdata_next[ddc_pkg::STAT_STANDBY] =
                    (pwr_reg == ddc_pkg::DDC_PWR_STANDBY);
            end
        end
    end

    // Standby follows the enables; one enabled channel keeps the strings powered.
    always_comb begin
        case (pwr_reg)
            ddc_pkg::DDC_PWR_ACTIVE: begin
                pwr_next = (mode_reg == '0) ? ddc_pkg::DDC_PWR_STANDBY
                                            : ddc_pkg::DDC_PWR_ACTIVE;
            end
            ddc_pkg::DDC_PWR_STANDBY: begin
                pwr_next = (mode_reg != '0) ? ddc_pkg::DDC_PWR_ACTIVE
                                            : ddc_pkg::DDC_PWR_STANDBY;
            end
            default: begin
                pwr_next = ddc_pkg::DDC_PWR_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            mode_reg  <= ddc_pkg::MODE_RESET;
            code_reg  <= '{default: ddc_pkg::CODE_RESET};
            rdata_reg <= '0;
            pwr_reg   <= ddc_pkg::DDC_PWR_ACTIVE;
        end else begin
            mode_reg  <= mode_next;
            code_reg  <= code_next;
            rdata_reg <= rdata_next;
            pwr_reg   <= pwr_next;
        end
    end

    // Tap n of the string sits n/256 of the span above the lower reference, so the
    // one-hot index equals the code and code zero lands on the lower reference.
    generate
        for (genvar g = 0; g < ddc_pkg::NUM_CH; g++) begin : g_ch
            ddc_tap_decoder u_tap (
                .i_clk     (I_REF_CLK),
                .i_rst_n   (I_RST_N),
                .i_en      (mode_reg[g]),
                .i_code    (code_reg[g]),
                .o_tap_sel (tap_sel[g]),
                .o_out_en  (out_en[g])
            );
        end
    endgenerate

    assign O_RDATA    = rdata_reg;
    assign O_TAP_SEL0 = tap_sel[0];
    assign O_TAP_SEL1 = tap_sel[1];
    assign O_OUT_EN   = out_en;
    // The standby state's one-hot code is bit 1, so the pin comes straight off a flop.
    assign O_STANDBY  = pwr_reg[1];

endmodule : ddc_dac_ctrl

//--- ddc_load_model.sv
// Purpose: Analog load on one converter output pin, reporting its level in millivolts.
// Assumes: Tap select is one-hot while the pin is driven.
// Notes:   A floating pin reports -1, since it has no defined level of its own.
`timescale 1ns/100ps
module ddc_load_model #(
    parameter int LOWER_MV = 0,
    parameter int UPPER_MV = 2560
) (
    input  wire logic [ddc_pkg::TAP_COUNT-1:0] i_tap_sel,
    input  wire logic                          i_out_en,
    output int                                 o_mv
);
    always_comb begin
        o_mv = -1;
        for (int n = 0; n < ddc_pkg::TAP_COUNT; n++) begin
            if (i_out_en === 1'b1 && i_tap_sel[n] === 1'b1) begin
                o_mv = LOWER_MV + n * (UPPER_MV - LOWER_MV) / ddc_pkg::TAP_COUNT;
            end
        end
    end
endmodule : ddc_load_model

//--- ddc_dac_ctrl_sva.sv
// Purpose: Concurrent checks on the converter control ports.
// Assumes: Outputs follow a register write by two clock edges.
// Notes:   Bound to every instance of the control block.
`timescale 1ns/100ps
module ddc_dac_ctrl_sva (
    input wire logic         I_REF_CLK,
    input wire logic         I_RST_N,
    input wire logic [7:0]   I_ADDR,
    input wire logic [7:0]   I_WDATA,
    input wire logic         I_WR,
    input wire logic         I_RD,
    input wire logic [7:0]   O_RDATA,
    input wire logic [255:0] O_TAP_SEL0,
    input wire logic [255:0] O_TAP_SEL1,
    input wire logic [1:0]   O_OUT_EN,
    input wire logic         O_STANDBY
);
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_N);
    wire logic [1:0] wd_en = I_WDATA[1:0];
    sequence mode_wr_s;
        I_WR && I_ADDR == ddc_pkg::OFF_MODE ##2 1'b1;
    endsequence
    sequence code0_wr_s;
        I_WR && I_ADDR == ddc_pkg::OFF_CODE0 ##2 O_OUT_EN[0];
    endsequence
    one_tap_a: assert property (O_OUT_EN[0] |-> $onehot(O_TAP_SEL0))
        else $error("channel 0 tap select not one-hot");
    off_hiz_a: assert property (!O_OUT_EN[1] |-> O_TAP_SEL1 == '0)
        else $error("disabled channel 1 still on a tap");
    reset_hiz_a: assert property (disable iff (1'b0) !I_RST_N |=> O_OUT_EN == 2'h0 && O_TAP_SEL0 == '0)
        else $error("output driven during reset");
    reset_val_a: assert property ($rose(I_RST_N) |=> O_OUT_EN == 2'h3 && O_TAP_SEL0[0] && O_TAP_SEL1[0])
        else $error("wrong output state after reset");
    code_tap_a: assert property (code0_wr_s |-> O_TAP_SEL0[$past(I_WDATA, 2)])
        else $error("written code not on tap");
    mode_en_a: assert property (mode_wr_s |-> O_OUT_EN == $past(wd_en, 2))
        else $error("enables do not follow mode write");
    standby_enables_a: assert property (mode_wr_s |-> O_STANDBY == ($past(wd_en, 2) == 2'h0))
        else $error("standby does not follow enables");
    mode_rsvd_a: assert property (I_RD && I_ADDR == ddc_pkg::OFF_MODE |=> O_RDATA[7:2] == 6'h00)
        else $error("reserved mode bits read nonzero");
    rdata_idle_a: assert property (!I_RD |=> O_RDATA == 8'h00)
        else $error("read data outside read cycle");
endmodule : ddc_dac_ctrl_sva
bind ddc_dac_ctrl ddc_dac_ctrl_sva ddc_dac_ctrl_sva_inst (.I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N),
    .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .O_TAP_SEL0(O_TAP_SEL0), .O_TAP_SEL1(O_TAP_SEL1), .O_OUT_EN(O_OUT_EN), .O_STANDBY(O_STANDBY));

//--- test_ddc_dac_ctrl.sv
// Purpose: Register-level test of the converter control block with loads on both pins.
// Assumes: Writes show at the pins two edges after the strobe edge.
// Notes:   Pin levels are reckoned from the reference span, so tap order errors show.
`timescale 1ns/100ps
module test_ddc_dac_ctrl;
    localparam int LO = 0;
    localparam int HI = 2560;
    logic         clk;
    logic         rst_n;
    logic         wr;
    logic         rd;
    logic [7:0]   addr;
    logic [7:0]   wdata;
    logic [7:0]   rdata;
    logic [255:0] tap0;
    logic [255:0] tap1;
    logic [1:0]   out_en;
    logic         standby;
    int           mv0;
    int           mv1;
    int           miscompares = 0;
    int           n_compared = 0;
    int           cycles = 0;
    always #2.5 clk = ~clk;
    ddc_dac_ctrl ddc_dac_ctrl_inst (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_TAP_SEL0(tap0),
        .O_TAP_SEL1(tap1), .O_OUT_EN(out_en), .O_STANDBY(standby));
    ddc_load_model #(.LOWER_MV(LO), .UPPER_MV(HI)) load0_inst (.i_tap_sel(tap0),
        .i_out_en(out_en[0]), .o_mv(mv0));
    ddc_load_model #(.LOWER_MV(LO), .UPPER_MV(HI)) load1_inst (.i_tap_sel(tap1),
        .i_out_en(out_en[1]), .o_mv(mv1));
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run
    task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val
    task automatic check_mv(input string what, input int exp, input int got);
        n_compared++;
        if (got != exp) begin
            miscompares++;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_mv
    // A negative code stands for a floating pin. Reset floats the pins without standby,
    // so the standby level is given on its own. Outputs are taken at the next edge.
    task automatic outs(input int c0, input int c1, input logic sb);
        @(posedge clk);
        check_mv("level0", (c0 < 0) ? -1 : LO + c0 * (HI - LO) / ddc_pkg::TAP_COUNT, mv0);
        check_mv("level1", (c1 < 0) ? -1 : LO + c1 * (HI - LO) / ddc_pkg::TAP_COUNT, mv1);
        check_val("standby", {7'h00, sb}, {7'h00, standby});
    endtask : outs
    // Every bus task starts and ends right after a rising edge.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
        @(posedge clk);
    endtask : wr_reg
    // Read data stand only in the cycle after the strobe, so they are taken at its end.
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input string what);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        @(posedge clk);
        check_val(what, exp, rdata);
    endtask : rd_reg
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        outs(0, 0, 1'b0);
        rd_reg(ddc_pkg::OFF_MODE, 8'h03, "mode");
        rd_reg(ddc_pkg::OFF_CODE0, 8'h00, "code0");
        wr_reg(ddc_pkg::OFF_CODE0, 8'hA5);
        wr_reg(ddc_pkg::OFF_CODE1, 8'hFF);
        outs(165, 255, 1'b0);
        rd_reg(ddc_pkg::OFF_CODE0, 8'hA5, "code0");
        rd_reg(ddc_pkg::OFF_CODE1, 8'hFF, "code1");
        wr_reg(ddc_pkg::OFF_MODE_BIT, 8'h00);
        outs(-1, 255, 1'b0);
        rd_reg(ddc_pkg::OFF_MODE, 8'h02, "mode");
        wr_reg(ddc_pkg::OFF_MODE, 8'h00);
        wr_reg(ddc_pkg::OFF_CODE0, 8'h3C);
        outs(-1, -1, 1'b1);
        rd_reg(ddc_pkg::OFF_STATUS, 8'h04, "status");
        wr_reg(ddc_pkg::OFF_MODE, 8'hFF);
        outs(60, 255, 1'b0);
        rd_reg(ddc_pkg::OFF_MODE, 8'h03, "mode");
        wr_reg(ddc_pkg::OFF_MODE_BIT, 8'h01);
        outs(60, -1, 1'b0);
        wr_reg(ddc_pkg::OFF_MODE_BIT, 8'h81);
        wr_reg(ddc_pkg::OFF_MODE_BIT, 8'h02);
        wr_reg(8'h20, 8'hFF);
        rd_reg(8'h20, 8'h00, "unmapped");
        rd_reg(ddc_pkg::OFF_MODE, 8'h03, "mode");
        rd_reg(ddc_pkg::OFF_CODE0, 8'h3C, "code0");
        rd_reg(ddc_pkg::OFF_STATUS, 8'h03, "status");
        rst_n <= 1'b0;
        @(posedge clk);
        outs(-1, -1, 1'b0);
        rst_n <= 1'b1;
        @(posedge clk);
        outs(0, 0, 1'b0);
        complete_run();
    end
endmodule : test_ddc_dac_ctrl
